/* rtl/enhanced_serial_port.sv */
`timescale 1ns/100ps
module enhanced_serial_port (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [esp_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // baud source
    input wire logic timer1_overflow,
    // serial pins
    output logic txd,
    input wire logic rxd_in,
    output logic rxd_out,
    output logic rxd_oe_n,
    // system
    output logic break_reset_req
);
    import esp_pkg::*;

    // ******************************************************
    // helpers
    // ******************************************************
    function automatic logic [3:0] stop_idx(input mode_t m);
        return (m == MODE_8BIT) ? STOP_IDX_8 : STOP_IDX_9;
    endfunction : stop_idx

    typedef enum {R_IDLE, R_START, R_BITS} rx_state_t;
    typedef enum {T_IDLE, T_SEND, T_SHIFT0} tx_state_t;

    // ******************************************************
    // registers
    // ******************************************************
    logic [7:0] serial_control_reg_q, serial_control_reg_d, serial_control_reg_w, rbuf_q, rbuf_d;
    logic fe_q, fe_d, brk_q, brk_d, tx_double_buffer_enable_q, rate_double_select_q, framing_view_select_q;
    logic [2:0] bgc_q;
    logic [15:0] div_q, brg_cnt_q;
    logic [31:0] prdata_q;
    logic brk_rst_q;

    // ******************************************************
    // apb decode
    // ******************************************************
    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire rd_setup = psel & ~penable & ~pwrite;
    wire hit_serial_control_reg = paddr == OFS_SERIAL_CONTROL_REG;
    wire hit_serial_data_buffer = paddr == OFS_SERIAL_DATA_BUFFER;
    wire hit_serial_status_reg = paddr == OFS_SERIAL_STATUS_REG;
    wire hit_power_control_reg = paddr == OFS_POWER_CONTROL_REG;
    wire hit_bgc = paddr == OFS_BGC;
    wire hit_divl = paddr == OFS_DIVL;
    wire hit_divh = paddr == OFS_DIVH;
    wire mapped = hit_serial_control_reg | hit_serial_data_buffer | hit_serial_status_reg | hit_power_control_reg | hit_bgc | hit_divl | hit_divh;
    wire wr_serial_control_reg = wr & hit_serial_control_reg;
    wire wr_serial_data_buffer = wr & hit_serial_data_buffer;
    wire wr_serial_status_reg = wr & hit_serial_status_reg;
    wire [7:0] wb = pwdata[7:0];

    // control bit 7 shows framing error instead of mode bit
    wire [7:0] serial_control_reg_view = {framing_view_select_q ? fe_q : serial_control_reg_q[SC_SM0], serial_control_reg_q[6:0]};
    wire [7:0] rd_val = hit_serial_control_reg ? serial_control_reg_view :
                        hit_serial_data_buffer ? rbuf_q :
                        hit_serial_status_reg ? {tx_double_buffer_enable_q, 5'h00, brk_q, fe_q} :
                        hit_power_control_reg ? {rate_double_select_q, framing_view_select_q, 6'h00} :
                        hit_bgc ? {5'h00, bgc_q} :
                        hit_divl ? div_q[7:0] :
                        hit_divh ? div_q[15:8] : 8'h00;

    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata = prdata_q;

    // ******************************************************
    // mode and baud ticks
    // ******************************************************
    wire mode_t mode = mode_t'(serial_control_reg_q[7:6]);
    wire ren = serial_control_reg_q[SC_REN];
    wire bg_en = bgc_q[BG_EN];
    wire bg_src = bgc_q[BG_SRC];
    logic t1_half_q, fix_half_q;

    wire brg_tick = bg_en & (brg_cnt_q == div_q);
    wire t1_tick = timer1_overflow & (rate_double_select_q | t1_half_q);
    wire var_tick = bg_src ? brg_tick : t1_tick;
    wire fix_tick = rate_double_select_q | fix_half_q;
    // one tick is a sixteenth of a bit; no timer 2 path exists
    wire os_tick = (mode == MODE_9FIX) ? fix_tick : var_tick;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brg_cnt_q <= RST_DIV;
            t1_half_q <= 1'b0;
            fix_half_q <= 1'b0;
        end else begin
            brg_cnt_q <= (!bg_en || brg_tick) ? RST_DIV : brg_cnt_q + 16'h0001;
            if (timer1_overflow) begin
                t1_half_q <= ~t1_half_q;
            end
            fix_half_q <= ~fix_half_q;
        end
    end

    // ******************************************************
    // receive pin synchroniser and break detect
    // ******************************************************
    logic rx_s1_q, rx_s2_q;
    logic rx_prev_q;
    logic [7:0] brk_cnt_q;
    wire rx_s = rx_s2_q;
    // start needs a falling edge: a line left low by a bad stop bit is no new frame
    wire rx_fall = rx_prev_q & ~rx_s;
    wire brk_set = (mode != MODE_SHIFT) & os_tick & ~rx_s & (brk_cnt_q == BRK_TICKS - 8'h01);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_s1_q <= 1'b1;
            rx_s2_q <= 1'b1;
            // idle level, so no false edge after reset
            rx_prev_q <= 1'b1;
            brk_cnt_q <= 8'h00;
        end else begin
            rx_s1_q <= rxd_in;
            rx_s2_q <= rx_s1_q;
            rx_prev_q <= rx_s;
            if (rx_s || mode == MODE_SHIFT) begin
                brk_cnt_q <= 8'h00;
            end else if (os_tick && brk_cnt_q != BRK_TICKS) begin
                brk_cnt_q <= brk_cnt_q + 8'h01;
            end
        end
    end

    // ******************************************************
    // asynchronous receiver
    // ******************************************************
    rx_state_t rx_state_q;
    logic [3:0] rx_tc_q, rx_bc_q;
    logic [8:0] rx_sh_q;
    wire rx_mid = (rx_state_q == R_BITS) & os_tick & (rx_tc_q == OS_LAST);
    wire rx_fin = rx_mid & (rx_bc_q == stop_idx(mode));
    wire rx_load = rx_fin & ~serial_control_reg_q[SC_RI];
    wire [7:0] rx_byte = (mode == MODE_8BIT) ? rx_sh_q[8:1] : rx_sh_q[7:0];
    wire rx_ninth = (mode == MODE_8BIT) ? rx_s : rx_sh_q[8];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state_q <= R_IDLE;
            rx_tc_q <= 4'h0;
            rx_bc_q <= 4'h0;
            rx_sh_q <= 9'h000;
        end else begin
            unique case (rx_state_q)
                R_IDLE: begin
                    rx_tc_q <= 4'h0;
                    if (ren && mode != MODE_SHIFT && rx_fall) begin
                        rx_state_q <= R_START;
                    end
                end
                R_START: begin
                    if (os_tick) begin
                        rx_tc_q <= rx_tc_q + 4'h1;
                        if (rx_tc_q == OS_HALF) begin
                            // glitch shorter than half a bit is no start
                            rx_state_q <= rx_s ? R_IDLE : R_BITS;
                            rx_tc_q <= 4'h0;
                            rx_bc_q <= 4'h1;
                        end
                    end
                end
                R_BITS: begin
                    if (os_tick) begin
                        rx_tc_q <= rx_tc_q + 4'h1;
                    end
                    if (rx_fin) begin
                        rx_state_q <= R_IDLE;
                    end else if (rx_mid) begin
                        rx_sh_q <= {rx_s, rx_sh_q[8:1]};
                        rx_bc_q <= rx_bc_q + 4'h1;
                    end
                end
            endcase
        end
    end

    // ******************************************************
    // transmitter and mode 0 shifter
    // ******************************************************
    tx_state_t tx_state_q;
    logic [3:0] tx_tc_q, tx_bc_q;
    logic [7:0] tx_dat_q;
    logic tx_n8_q, hb_v_q, m0_rx_q, txd_q, rxo_q, rxoe_n_q;
    logic [8:0] hb_q;

    wire db = tx_double_buffer_enable_q & (mode != MODE_SHIFT);
    wire idle = tx_state_q == T_IDLE;
    wire tx_end_bit = (tx_state_q == T_SEND) & os_tick & (tx_tc_q == OS_LAST);
    wire tx_last = tx_bc_q == stop_idx(mode);
    wire tx_chain = tx_end_bit & tx_last & db & hb_v_q;
    wire take = (idle & hb_v_q & (mode != MODE_SHIFT)) | tx_chain;
    wire take0 = idle & hb_v_q & (mode == MODE_SHIFT);
    wire m0_rx_go = idle & ~hb_v_q & (mode == MODE_SHIFT) & ren & ~serial_control_reg_q[SC_RI];
    wire [3:0] tx_tc_inc = tx_tc_q + 4'h1;
    wire m0_fin = (tx_state_q == T_SHIFT0) & (tx_tc_q == OS_LAST) & (tx_bc_q == M0_LAST_BIT);
    // single buffered: ninth bit read live so software may set it late
    wire tx_ninth = db ? tx_n8_q : serial_control_reg_q[SC_TB8];
    wire [3:0] nb = tx_bc_q + 4'h1;
    wire nb_line = (nb <= 4'h8) ? tx_dat_q[nb[2:0] - 3'h1] :
                   (nb == NINTH_IDX && mode != MODE_8BIT) ? tx_ninth : 1'b1;

    wire ti_set = (take & db) | (tx_end_bit & tx_last & ~db) | (m0_fin & ~m0_rx_q);
    wire ri_set = rx_load | (m0_fin & m0_rx_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_q <= T_IDLE;
            tx_tc_q <= 4'h0;
            tx_bc_q <= 4'h0;
            tx_dat_q <= RST_BYTE;
            tx_n8_q <= 1'b0;
            hb_q <= 9'h000;
            hb_v_q <= 1'b0;
            m0_rx_q <= 1'b0;
            txd_q <= 1'b1;
            rxo_q <= 1'b1;
            rxoe_n_q <= 1'b1;
        end else begin
            if (wr_serial_data_buffer) begin
                hb_q <= {serial_control_reg_q[SC_TB8], wb};
                hb_v_q <= 1'b1;
            end else if (take || take0) begin
                hb_v_q <= 1'b0;
            end
            if (take) begin
                tx_state_q <= T_SEND;
                tx_dat_q <= hb_q[7:0];
                tx_n8_q <= hb_q[8];
                tx_tc_q <= 4'h0;
                tx_bc_q <= 4'h0;
                txd_q <= 1'b0;
            end else if (take0 || m0_rx_go) begin
                tx_state_q <= T_SHIFT0;
                tx_dat_q <= take0 ? hb_q[7:0] : 8'hFF;
                m0_rx_q <= ~take0;
                tx_tc_q <= 4'h0;
                tx_bc_q <= 4'h0;
                txd_q <= 1'b0;
                rxo_q <= take0 ? hb_q[0] : 1'b1;
                rxoe_n_q <= ~take0;
            end else if (tx_state_q == T_SEND) begin
                if (os_tick) begin
                    tx_tc_q <= tx_tc_inc;
                end
                if (tx_end_bit && tx_last) begin
                    tx_state_q <= T_IDLE;
                    txd_q <= 1'b1;
                end else if (tx_end_bit) begin
                    tx_bc_q <= nb;
                    txd_q <= nb_line;
                end
            end else if (tx_state_q == T_SHIFT0) begin
                // clock low for eight cycles, high for eight
                tx_tc_q <= tx_tc_inc;
                txd_q <= m0_fin | tx_tc_inc[3];
                if (tx_tc_q == OS_LAST) begin
                    tx_dat_q <= {rx_s, tx_dat_q[7:1]};
                    tx_bc_q <= nb;
                    rxo_q <= m0_fin | m0_rx_q | tx_dat_q[1];
                end
                if (m0_fin) begin
                    tx_state_q <= T_IDLE;
                    rxoe_n_q <= 1'b1;
                end
            end
        end
    end

    assign txd = txd_q;
    assign rxd_out = rxo_q;
    assign rxd_oe_n = rxoe_n_q;

    // ******************************************************
    // control and status registers
    // ******************************************************
    // with view select set, a write to bit 7 reaches the error flag
    assign serial_control_reg_w = wr_serial_control_reg ? {framing_view_select_q ? serial_control_reg_q[SC_SM0] : wb[SC_SM0], wb[6:0]} : serial_control_reg_q;
    assign serial_control_reg_d = {serial_control_reg_w[7:3], rx_load ? rx_ninth : serial_control_reg_w[SC_RB8],
                     serial_control_reg_w[SC_TI] | ti_set, serial_control_reg_w[SC_RI] | ri_set};
    assign rbuf_d = rx_load ? rx_byte : (m0_fin & m0_rx_q) ? {rx_s, tx_dat_q[7:1]} : rbuf_q;
    assign fe_d = (rx_fin & ~rx_s) |
                  ((wr_serial_control_reg & framing_view_select_q) ? fe_q & wb[SC_SM0] :
                   wr_serial_status_reg ? fe_q & wb[SS_FE] : fe_q);
    assign brk_d = brk_set | (wr_serial_status_reg ? brk_q & wb[SS_BRK] : brk_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_control_reg_q <= RST_BYTE;
            rbuf_q <= RST_BYTE;
            fe_q <= 1'b0;
            brk_q <= 1'b0;
            brk_rst_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            serial_control_reg_q <= serial_control_reg_d;
            rbuf_q <= rbuf_d;
            fe_q <= fe_d;
            brk_q <= brk_d;
            brk_rst_q <= brk_d & bgc_q[BG_BRST];
            if (rd_setup) begin
                prdata_q <= {24'h00_0000, rd_val};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_double_buffer_enable_q <= 1'b0;
            rate_double_select_q <= 1'b0;
            framing_view_select_q <= 1'b0;
            bgc_q <= 3'h0;
            div_q <= RST_DIV;
        end else if (wr) begin
            if (hit_serial_status_reg) begin
                tx_double_buffer_enable_q <= wb[SS_TX_DOUBLE_BUFFER_ENABLE];
            end
            if (hit_power_control_reg) begin
                rate_double_select_q <= wb[PC_RATE_DOUBLE_SELECT];
                framing_view_select_q <= wb[PC_FRAMING_VIEW_SELECT];
            end
            if (hit_bgc) begin
                bgc_q <= wb[2:0];
            end
            if (hit_divl) begin
                div_q[7:0] <= wb;
            end
            if (hit_divh) begin
                div_q[15:8] <= wb;
            end
        end
    end

    assign break_reset_req = brk_rst_q;
endmodule : enhanced_serial_port

/* shared/esp_pkg.sv */
package esp_pkg;
    // ******************************************************
    // bus and register map
    // ******************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_SERIAL_CONTROL_REG = 8'h00;
    localparam logic [7:0] OFS_SERIAL_DATA_BUFFER = 8'h04;
    localparam logic [7:0] OFS_SERIAL_STATUS_REG = 8'h08;
    localparam logic [7:0] OFS_POWER_CONTROL_REG = 8'h0C;
    localparam logic [7:0] OFS_BGC = 8'h10;
    localparam logic [7:0] OFS_DIVL = 8'h14;
    localparam logic [7:0] OFS_DIVH = 8'h18;
    // ******************************************************
    // field positions
    // ******************************************************
    localparam int SC_SM0 = 7;
    localparam int SC_REN = 4;
    localparam int SC_TB8 = 3;
    localparam int SC_RB8 = 2;
    localparam int SC_TI = 1;
    localparam int SC_RI = 0;
    localparam int SS_TX_DOUBLE_BUFFER_ENABLE = 7;
    localparam int SS_BRK = 1;
    localparam int SS_FE = 0;
    localparam int PC_RATE_DOUBLE_SELECT = 7;
    localparam int PC_FRAMING_VIEW_SELECT = 6;
    localparam int BG_EN = 0;
    localparam int BG_SRC = 1;
    localparam int BG_BRST = 2;
    // ******************************************************
    // reset values
    // ******************************************************
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_DIV = 16'h0000;
    // ******************************************************
    // timing
    // ******************************************************
    localparam logic [3:0] OS_LAST = 4'hF;
    localparam logic [3:0] OS_HALF = 4'h7;
    localparam logic [3:0] M0_LAST_BIT = 4'h7;
    localparam logic [7:0] BRK_TICKS = 8'hB0;
    localparam logic [3:0] STOP_IDX_8 = 4'h9;
    localparam logic [3:0] STOP_IDX_9 = 4'hA;
    localparam logic [3:0] NINTH_IDX = 4'h9;

    typedef enum logic [1:0] {MODE_SHIFT, MODE_8BIT, MODE_9FIX, MODE_9VAR} mode_t;
endpackage : esp_pkg

/* testbench/esp_props.sv */
`timescale 1ns/100ps
module esp_props (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [esp_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // pins
    input wire logic txd,
    input wire logic rxd_in,
    input wire logic rxd_out,
    input wire logic rxd_oe_n,
    input wire logic break_reset_req
);
    import esp_pkg::*;
    // ****
    // helpers
    // ****
    logic [7:0] low_q;
    logic [7:0] low_d;
    wire mapped = paddr inside {OFS_SERIAL_CONTROL_REG, OFS_SERIAL_DATA_BUFFER, OFS_SERIAL_STATUS_REG, OFS_POWER_CONTROL_REG, OFS_BGC, OFS_DIVL, OFS_DIVH};
    wire apb_wr = psel && penable && pwrite;
    // saturating run length of a low receive line
    assign low_d = rxd_in ? 8'h00 : (low_q == 8'hFF ? low_q : low_q + 8'h01);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_q <= 8'h00;
        end else begin
            low_q <= low_d;
        end
    end
    // ****
    // properties
    // ****
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence rd_unmapped_s;
        psel && !penable && !pwrite && !mapped ##1 penable;
    endsequence
    sequence clk_low_s;
        (!txd) [*8];
    endsequence
    unmapped_err_a: assert property (psel && penable && !mapped |-> pslverr)
        else $error("unmapped access without slave error");
    mapped_ok_a: assert property (psel && penable && mapped |-> !pslverr)
        else $error("slave error on mapped access");
    unmapped_rd_a: assert property (rd_unmapped_s |-> prdata == 32'h0)
        else $error("unmapped read data not zero");
    upper_zero_a: assert property (prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    start_len_a: assert property ($fell(txd) |-> clk_low_s)
        else $error("start bit too short");
    shift_clk_a: assert property ($fell(txd) && !rxd_oe_n |-> clk_low_s ##1 txd)
        else $error("shift clock low phase wrong");
    shift_data_a: assert property (!rxd_oe_n && txd && $past(txd) |-> $stable(rxd_out))
        else $error("shift data moved in high phase");
    break_cause_a: assert property ($rose(break_reset_req) && !$past(apb_wr, 2) |-> low_q >= BRK_TICKS)
        else $error("break flagged on short low");
endmodule : esp_props

bind enhanced_serial_port esp_props esp_props_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .txd(txd), .rxd_in(rxd_in),
    .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n), .break_reset_req(break_reset_req));

/* testbench/serial_peer.sv */
`timescale 1ns/100ps
module serial_peer (
    // clock
    input wire logic pclk,
    // line
    input wire logic txd,
    output logic rxd_drv
);
    // idle line rests high
    initial rxd_drv = 1'b1;
    task automatic send(input logic [10:0] bits, input int n, input int per);
        for (int i = 0; i < n; i++) begin
            rxd_drv <= bits[i];
            repeat (per) @(posedge pclk);
        end
        rxd_drv <= 1'b1;
    endtask : send
    // mode 0 receive: next bit after each falling shift clock
    task automatic shift_in(input logic [7:0] d, input int lim);
        logic p;
        int i;
        int w;
        p = 1'b1;
        i = 0;
        w = 0;
        while (i < 8 && w < lim) begin
            @(posedge pclk);
            w++;
            if (p && !txd) begin
                rxd_drv <= d[i];
                i++;
            end
            p = txd;
        end
        // hold the last bit past its sampling point, then idle high
        repeat (16) @(posedge pclk);
        rxd_drv <= 1'b1;
    endtask : shift_in
    // returns at mid stop bit so a following start is not missed
    task automatic recv(input int n, input int per, output logic [10:0] bits, output time t0);
        int w;
        bits = 'x;
        w = 0;
        t0 = 0;
        do begin
            @(posedge pclk);
            w++;
        end while (txd !== 1'b0 && w < 20000);
        if (w < 20000) begin
            t0 = $time;
            repeat (per / 2) @(posedge pclk);
            for (int i = 0; i < n; i++) begin
                bits[i] = txd;
                if (i < n - 1) repeat (per) @(posedge pclk);
            end
        end
    endtask : recv
endmodule : serial_peer

/* testbench/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
    import esp_pkg::*;
    // ****
    // wiring
    // ****
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic timer1_overflow = 1'b0;
    logic t1_on = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, txd, rxd_out, rxd_oe_n, break_reset_req, rxd_drv;
    int num_errors = 0;
    int samples_checked = 0;
    // receive pin carries design data while shift mode transmits
    wire rxd_line = rxd_oe_n ? rxd_drv : rxd_out;
    always #4 pclk = ~pclk;
    always @(posedge pclk) timer1_overflow <= t1_on;
    enhanced_serial_port enhanced_serial_port_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer1_overflow(timer1_overflow), .txd(txd), .rxd_in(rxd_line), .rxd_out(rxd_out),
        .rxd_oe_n(rxd_oe_n), .break_reset_req(break_reset_req));
    serial_peer serial_peer_inst (.pclk(pclk), .txd(txd), .rxd_drv(rxd_drv));
    // ****
    // tasks
    // ****
    task automatic stop_test();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [31:0] q, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            num_errors++;
            stop_test();
        end
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic e;
        xfer(1'b1, a, d, q, e);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        logic e;
        xfer(1'b0, a, 8'h00, q, e);
    endtask : rd
    function automatic logic [10:0] frame(input logic [7:0] d, input logic nine);
        return {1'b1, nine, d, 1'b0};
    endfunction : frame
    task automatic tx_chk(input logic [7:0] d, input logic nine, input int n, input int per, input logic [7:0] ctl);
        logic [10:0] b;
        logic [31:0] q;
        time t;
        wr(OFS_SERIAL_CONTROL_REG, ctl);
        fork
            begin
                wr(OFS_SERIAL_DATA_BUFFER, d);
                rd(OFS_SERIAL_CONTROL_REG, q);
            end
            serial_peer_inst.recv(n, per, b, t);
        join
        chk("single buffer flag", 32'h0, {31'h0, q[SC_TI]});
        chk("tx frame", {21'h0, frame(d, nine) & ~(11'h7FF << n)}, {21'h0, b & ~(11'h7FF << n)});
        repeat (per) @(posedge pclk);
    endtask : tx_chk
    task automatic rx_chk(input logic [7:0] d, input logic nine, input int n, input int per, input logic [7:0] ctl);
        logic [31:0] q;
        serial_peer_inst.send(frame(d, nine), n, per);
        rd(OFS_SERIAL_DATA_BUFFER, q);
        chk("rx data", {24'h0, d}, q);
        rd(OFS_SERIAL_CONTROL_REG, q);
        chk("rx ninth", {31'h0, nine}, {31'h0, q[SC_RB8]});
        wr(OFS_SERIAL_CONTROL_REG, ctl);
    endtask : rx_chk
    // ****
    // main sequence
    // ****
    initial begin
        logic [31:0] q;
        logic e, nine, p;
        logic [7:0] d, b0;
        logic [10:0] b1, b2;
        time t1, t2;
        int per, k, w;
        void'($urandom(32'h6627));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            rd(8'(i * 4), q);
            chk("reset value", 32'h0, q);
        end
        xfer(1'b0, 8'h1C, 8'hA5, q, e);
        chk("unmapped read", 32'h1, {q[30:0], e});
        for (int r = 0; r < 2; r++) begin
            nine = 1'($urandom);
            per = r ? 16 : 32;
            wr(OFS_POWER_CONTROL_REG, r ? 8'h80 : 8'h00);
            tx_chk(8'($urandom), nine, 11, per, {4'h9, nine, 3'h0});
            rx_chk(8'($urandom), nine, 11, per, 8'h90);
        end
        t1_on <= 1'b1;
        wr(OFS_POWER_CONTROL_REG, 8'h00);
        d = 8'($urandom);
        tx_chk(d, 1'b0, 11, 32, 8'hD0);
        rx_chk(~d, 1'b1, 11, 32, 8'hD0);
        t1_on <= 1'b0;
        wr(OFS_DIVH, 8'h5A);
        rd(OFS_DIVH, q);
        chk("divisor high", 32'h5A, q);
        wr(OFS_DIVH, 8'h00);
        per = 16 * (($urandom % 3) + 1);
        wr(OFS_DIVL, 8'(per / 16 - 1));
        wr(OFS_BGC, 8'h03);
        tx_chk(d, 1'b1, 10, per, 8'h50);
        rx_chk(d, 1'b1, 10, per, 8'h50);
        rd(OFS_SERIAL_STATUS_REG, q);
        chk("no framing error", 32'h0, {31'h0, q[SS_FE]});
        rx_chk(~d, 1'b0, 10, per, 8'h50);
        rd(OFS_SERIAL_STATUS_REG, q);
        chk("framing error", 32'h1, {31'h0, q[SS_FE]});
        wr(OFS_POWER_CONTROL_REG, 8'h40);
        rd(OFS_SERIAL_CONTROL_REG, q);
        chk("framing view", 32'h1, {31'h0, q[SC_SM0]});
        wr(OFS_POWER_CONTROL_REG, 8'h00);
        wr(OFS_BGC, 8'h07);
        serial_peer_inst.send(11'h000, 11, 2 * per);
        @(posedge pclk);
        chk("break request", 32'h1, {31'h0, break_reset_req});
        rd(OFS_SERIAL_STATUS_REG, q);
        chk("break flag", 32'h1, {31'h0, q[SS_BRK]});
        wr(OFS_SERIAL_STATUS_REG, 8'h00);
        @(posedge pclk);
        chk("break cleared", 32'h0, {31'h0, break_reset_req});
        wr(OFS_SERIAL_CONTROL_REG, 8'h80);
        wr(OFS_POWER_CONTROL_REG, 8'h80);
        wr(OFS_SERIAL_STATUS_REG, 8'h80);
        wr(OFS_SERIAL_CONTROL_REG, 8'h88);
        d = 8'($urandom);
        fork
            begin
                wr(OFS_SERIAL_DATA_BUFFER, d);
                rd(OFS_SERIAL_CONTROL_REG, q);
                wr(OFS_SERIAL_CONTROL_REG, 8'h80);
                wr(OFS_SERIAL_DATA_BUFFER, ~d);
            end
            begin
                serial_peer_inst.recv(11, 16, b1, t1);
                serial_peer_inst.recv(11, 16, b2, t2);
            end
        join
        chk("early tx flag", 32'h1, {31'h0, q[SC_TI]});
        chk("first frame", {21'h0, frame(d, 1'b1)}, {21'h0, b1});
        chk("second frame", {21'h0, frame(~d, 1'b0)}, {21'h0, b2});
        chk("frame spacing", 32'h580, 32'(t2 - t1));
        repeat (16) @(posedge pclk);
        wr(OFS_SERIAL_STATUS_REG, 8'h00);
        wr(OFS_SERIAL_CONTROL_REG, 8'h00);
        d = 8'($urandom);
        b0 = 'x;
        p = 1'b1;
        k = 0;
        w = 0;
        fork
            wr(OFS_SERIAL_DATA_BUFFER, d);
            while (k < 8 && w < 4000) begin
                @(posedge pclk);
                w++;
                if (txd && !p && !rxd_oe_n) begin
                    b0[k] = rxd_out;
                    k++;
                end
                p = txd;
            end
        join
        chk("shift data", {24'h0, d}, {24'h0, b0});
        d = 8'($urandom);
        fork
            wr(OFS_SERIAL_CONTROL_REG, 8'h10);
            serial_peer_inst.shift_in(d, 4000);
        join
        rd(OFS_SERIAL_DATA_BUFFER, q);
        chk("shift receive", {24'h0, d}, q);
        rd(OFS_SERIAL_CONTROL_REG, q);
        chk("shift receive flag", 32'h1, {31'h0, q[SC_RI]});
        stop_test();
    end
endmodule : tb_top
